//--- verilog/pciu_top.sv
`timescale 1ns/100ps
// What this block does
// - Group enable plus unmasked pin change requests
// - Each group has its own vector
// - Pin change sets that group's pending flag
// - Vector only when flag, global, enable
// - Handler execution clears group's pending flag
// - Write one clears flag, zero keeps
// - Flag bits 7..3 read zero
// - Mask bit and group enable allow pin
// - Group 1 mask bit 7 reads zero
// - Mask registers reset to zero
// - Enable register bits 7..3 read zero
module pciu_top
    import pciu_pkg::*;
(
    // Clock and reset
    input  wire logic          i_clk,
    input  wire logic          i_rst,
    // Register port
    input  wire logic [7:0]    i_addr,
    input  wire logic [7:0]    i_wdata,
    input  wire logic          i_wr,
    input  wire logic          i_rd,
    output logic      [7:0]    o_rdata,
    // Monitored pins
    input  wire pciu_pins_type i_pins,
    // Processor core side
    input  wire logic          i_global_enable,
    input  wire logic [2:0]    i_handler_ack,
    output logic      [2:0]    o_group_request,
    output logic      [2:0]    o_group_vector,
    output logic               o_irq
);

    logic [7:0] pin_mask_group0_r;
    logic [7:0] pin_mask_group1_r;
    logic [7:0] pin_mask_group2_r;
    logic [2:0] change_group_enable_r;
    logic [2:0] change_group_flags_r;
    logic [2:0] irq_mask_r;
    logic [2:0] hit;
    logic [2:0] req_nxt;
    logic [7:0] rdata_nxt;
    logic [7:0] change [PCIU_NGRP];
    logic [7:0] pins   [PCIU_NGRP];
    logic [7:0] masks  [PCIU_NGRP];

    // Register write decode
    function automatic logic wr_hit(input logic [7:0] a, input logic [7:0] ofs, input logic w);
        wr_hit = w && (a == ofs);
    endfunction

    assign pins[0]  = i_pins.group0_pin_sources;
    assign pins[1]  = {1'b0, i_pins.group1_pin_sources};
    assign pins[2]  = i_pins.group2_pin_sources;
    assign masks[0] = pin_mask_group0_r;
    assign masks[1] = pin_mask_group1_r;
    assign masks[2] = pin_mask_group2_r;

    // One synchroniser and change detector per group
    genvar g;
    generate
        for (g = 0; g < PCIU_NGRP; g++) begin : g_grp
            pciu_sync u_sync (
                .i_clk    (i_clk),
                .i_rst    (i_rst),
                .i_pin    (pins[g]),
                .o_change (change[g])
            );
            // A masked pin or a disabled group cannot raise the flag
            assign hit[g] = change_group_enable_r[g] && |(change[g] & masks[g]);
        end
    endgenerate

    // Mask registers; group 1 top bit is not implemented
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            pin_mask_group0_r <= PCIU_RST_MASK;
            pin_mask_group1_r <= PCIU_RST_MASK;
            pin_mask_group2_r <= PCIU_RST_MASK;
        end else begin
            if (wr_hit(i_addr, PCIU_OFS_MASK0, i_wr)) begin
                pin_mask_group0_r <= i_wdata;
            end
            if (wr_hit(i_addr, PCIU_OFS_MASK1, i_wr)) begin
                pin_mask_group1_r <= i_wdata & PCIU_MASK1_IMPL;
            end
            if (wr_hit(i_addr, PCIU_OFS_MASK2, i_wr)) begin
                pin_mask_group2_r <= i_wdata;
            end
        end
    end

    // Group enable and interrupt line mask
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            change_group_enable_r <= PCIU_RST_GRP;
            irq_mask_r            <= PCIU_RST_GRP;
        end else begin
            if (wr_hit(i_addr, PCIU_OFS_ENABLE, i_wr)) begin
                change_group_enable_r <= i_wdata[2:0];
            end
            if (wr_hit(i_addr, PCIU_OFS_IMASK, i_wr)) begin
                irq_mask_r <= i_wdata[2:0];
            end
        end
    end

    // Pending flags: a new change wins over handler or software clear
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            change_group_flags_r <= PCIU_RST_GRP;
        end else begin
            for (int k = 0; k < PCIU_NGRP; k++) begin
                if (hit[k]) begin
                    change_group_flags_r[k] <= 1'b1;
                end else if (i_handler_ack[k]) begin
                    change_group_flags_r[k] <= 1'b0;
                end else if (wr_hit(i_addr, PCIU_OFS_FLAGS, i_wr) && i_wdata[k]) begin
                    change_group_flags_r[k] <= 1'b0;
                end
            end
        end
    end

    // Requests and vectors, registered so outputs come from flops
    always_comb begin
        req_nxt = change_group_flags_r & change_group_enable_r;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_group_request <= PCIU_RST_GRP;
            o_group_vector  <= PCIU_RST_GRP;
            o_irq           <= 1'b0;
        end else begin
            o_group_request <= req_nxt;
            // Each group drives its own vector line, only with global enable
            o_group_vector  <= i_global_enable ? req_nxt : PCIU_RST_GRP;
            o_irq           <= |(change_group_flags_r & irq_mask_r);
        end
    end

    // Read mux; unmapped addresses and unused bits read zero
    always_comb begin
        rdata_nxt = 8'h00;
        if (i_addr == PCIU_OFS_MASK0) begin
            rdata_nxt = pin_mask_group0_r;
        end else if (i_addr == PCIU_OFS_MASK1) begin
            rdata_nxt = pin_mask_group1_r & PCIU_MASK1_IMPL;
        end else if (i_addr == PCIU_OFS_MASK2) begin
            rdata_nxt = pin_mask_group2_r;
        end else if (i_addr == PCIU_OFS_ENABLE) begin
            rdata_nxt = {5'h00, change_group_enable_r};
        end else if (i_addr == PCIU_OFS_FLAGS) begin
            rdata_nxt = {5'h00, change_group_flags_r};
        end else if (i_addr == PCIU_OFS_IMASK) begin
            rdata_nxt = {5'h00, irq_mask_r};
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
        end else if (i_rd) begin
            o_rdata <= rdata_nxt;
        end else begin
            o_rdata <= 8'h00;
        end
    end

endmodule // pciu_top

//--- verilog/pciu_pkg.sv
package pciu_pkg;

    // Register offsets; mask offsets as printed, enable and flag offsets chosen locally
    localparam logic [7:0] PCIU_OFS_MASK0  = 8'h6B;
    localparam logic [7:0] PCIU_OFS_MASK1  = 8'h6C;
    localparam logic [7:0] PCIU_OFS_MASK2  = 8'h6D;
    localparam logic [7:0] PCIU_OFS_ENABLE = 8'h68;
    localparam logic [7:0] PCIU_OFS_FLAGS  = 8'h3B;
    localparam logic [7:0] PCIU_OFS_IMASK  = 8'h6E;

    // Reset values
    localparam logic [7:0] PCIU_RST_MASK   = 8'h00;
    localparam logic [2:0] PCIU_RST_GRP    = 3'h0;

    // Group geometry
    localparam int PCIU_NGRP    = 3;
    localparam int PCIU_GRP_W   = 8;
    localparam logic [7:0] PCIU_MASK1_IMPL = 8'h7F;
    localparam logic [7:0] PCIU_MASK_FULL  = 8'hFF;

    // Pin sources for the three groups
    typedef struct packed {
        logic [7:0] group2_pin_sources;
        logic [6:0] group1_pin_sources;
        logic [7:0] group0_pin_sources;
    } pciu_pins_type;

    // Register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } pciu_req_type;

endpackage

//--- verilog/pciu_sync.sv
`timescale 1ns/100ps
// Two-stage synchroniser plus a third stage for change detection
module pciu_sync
    import pciu_pkg::*;
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Pin side
    input  wire logic [7:0] i_pin,
    // Change output
    output logic      [7:0] o_change
);

    logic [7:0] meta_r;
    logic [7:0] sync_r;
    logic [7:0] prev_r;

    // First stage feeds only the second; reset sampling avoids a false change
    always_ff @(posedge i_clk) begin
        meta_r <= i_pin;
        sync_r <= meta_r;
        if (i_rst) begin
            prev_r <= sync_r;
        end else begin
            prev_r <= sync_r;
        end
    end

    // Difference of two successive synchronised samples
    assign o_change = sync_r ^ prev_r;

endmodule // pciu_sync

//--- verif/pciu_core_model.sv
`timescale 1ns/100ps
// Core model: one acknowledge per taken vector, as on handler entry
module pciu_core_model (
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // Core side; i_en low holds every acknowledge at zero
    input  wire logic       i_en,
    input  wire logic [2:0] i_vector,
    output logic      [2:0] o_ack
);
    logic [2:0] hold_r; // Vector lingers after the ack, so block re-entry
    logic [2:0] hold2_r;
    // Acknowledge a vector once
    always_ff @(posedge i_clk) begin
        o_ack   <= (i_rst || !i_en) ? 3'h0 : i_vector & ~o_ack & ~hold_r & ~hold2_r;
        hold_r  <= i_rst ? 3'h0 : o_ack;
        hold2_r <= i_rst ? 3'h0 : hold_r;
    end
endmodule // pciu_core_model

//--- verif/pciu_top_chk.sv
`timescale 1ns/100ps
module pciu_top_chk
    import pciu_pkg::*;
(
    // Watched ports
    input wire logic          i_clk,
    input wire logic          i_rst,
    input wire logic [7:0]    i_addr,
    input wire logic [7:0]    i_wdata,
    input wire logic          i_wr,
    input wire logic          i_rd,
    input wire logic [7:0]    o_rdata,
    input wire pciu_pins_type i_pins,
    input wire logic          i_global_enable,
    input wire logic [2:0]    i_handler_ack,
    input wire logic [2:0]    o_group_request,
    input wire logic [2:0]    o_group_vector,
    input wire logic          o_irq
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (i_rst);
    logic [2:0] quiet_r; // Edges with steady pins; a late change may set a flag again
    logic       wr_r;
    // Helper state
    always_ff @(posedge i_clk) begin
        quiet_r <= (i_rst || !$stable(i_pins)) ? 3'h0 : quiet_r + {2'h0, quiet_r != 3'h7};
        wr_r    <= !i_rst && (wr_r || i_wr);
    end
    a_vec_sub: assert property ((o_group_vector & ~(o_group_request | $past(o_group_request))) == 3'h0)
        else $error("vector without request");
    a_vec_global: assert property (|o_group_vector |-> $past(i_global_enable))
        else $error("vector with global enable low");
    a_flag_high: assert property (i_rd && i_addr == PCIU_OFS_FLAGS |=> o_rdata[7:3] == 5'h00)
        else $error("flag high bits set");
    a_mask1_top: assert property (i_rd && i_addr == PCIU_OFS_MASK1 |=> !o_rdata[7])
        else $error("mask1 bit7 set");
    a_enable_high: assert property (i_rd && i_addr == PCIU_OFS_ENABLE |=> o_rdata[7:3] == 5'h00)
        else $error("enable high bits set");
    a_ack_clear: assert property (|i_handler_ack && quiet_r > 3'h3 |-> ##2
        (o_group_request & $past(i_handler_ack, 2)) == 3'h0) else $error("ack kept flag");
    a_w1c_clear: assert property (i_wr && i_addr == PCIU_OFS_FLAGS && quiet_r > 3'h3 |-> ##2
        (o_group_request & $past(i_wdata[2:0], 2)) == 3'h0) else $error("write one kept flag");
    a_reset_quiet: assert property (o_group_request != 3'h0 |-> wr_r)
        else $error("request before any write");
    c_ack: cover property (|i_handler_ack);
    c_irq: cover property (o_irq);
    c_vec2: cover property ($rose(o_group_vector[2]));
endmodule // pciu_top_chk

bind pciu_top pciu_top_chk u_chk (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pins,
    .i_global_enable, .i_handler_ack, .o_group_request, .o_group_vector, .o_irq);

//--- verif/tb_pciu.sv
`timescale 1ns/100ps
module tb_pciu;
    import pciu_pkg::*;
    logic          i_clk = 1'b0, i_rst = 1'b1, i_wr = 1'b0, i_rd = 1'b0, i_global_enable = 1'b0, core_en = 1'b0;
    logic [7:0]    i_addr = 8'h00, i_wdata = 8'h00, o_rdata;
    logic [2:0]    ack, req, vec;
    logic          irq;
    pciu_pins_type i_pins = '0;
    int            failures = 0, checked = 0, n;
    // 25 MHz clock
    always #20 i_clk = ~i_clk;
    pciu_top dut (.i_clk, .i_rst, .i_addr, .i_wdata, .i_wr, .i_rd, .o_rdata, .i_pins, .i_global_enable,
        .i_handler_ack(ack), .o_group_request(req), .o_group_vector(vec), .o_irq(irq));
    pciu_core_model core (.i_clk, .i_rst, .i_en(core_en), .i_vector(vec), .o_ack(ack));
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic test_done;
        $display("checked=%0d failures=%0d", checked, failures);
        if (failures == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic tick(input int k);
        repeat (k) @(posedge i_clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1 chk(o_rdata, e);
    endtask
    function automatic logic [2:0] exp_flags(input logic [22:0] d, input logic [7:0] m0, m1, m2, input logic [2:0] en);
        return en & {|(d[22:15] & m2), |(d[14:8] & m1[6:0]), |(d[7:0] & m0)};
    endfunction
    // Program masks, move pins, then check flags, outputs and clearing; m2 low bits double as irq mask
    task automatic trial(input logic [7:0] m0, m1, m2, input logic [2:0] en, input logic [22:0] p, input logic ge);
        logic [2:0] f;
        f = exp_flags(p ^ i_pins, m0, m1, m2, en);
        wr(PCIU_OFS_MASK0, m0);
        wr(PCIU_OFS_MASK1, m1);
        wr(PCIU_OFS_MASK2, m2);
        wr(PCIU_OFS_ENABLE, {5'h1F, en});
        wr(PCIU_OFS_IMASK, {5'h00, m2[2:0]});
        wr(PCIU_OFS_FLAGS, 8'hFF);
        i_global_enable <= ge;
        i_pins <= p;
        tick(6);
        #1 chk({5'h00, req}, {5'h00, f});
        chk({5'h00, vec}, {5'h00, f & {3{ge}}});
        chk({7'h00, irq}, {7'h00, |(f & m2[2:0])});
        rd(PCIU_OFS_MASK1, {1'b0, m1[6:0]});
        rd(PCIU_OFS_ENABLE, {5'h00, en});
        wr(PCIU_OFS_FLAGS, 8'h00);
        rd(PCIU_OFS_FLAGS, {5'h00, f});
        wr(PCIU_OFS_FLAGS, {5'h00, f});
        rd(PCIU_OFS_FLAGS, 8'h00);
    endtask
    initial begin
        void'($urandom(32'hEF17AD2D));
        tick(20);
        i_rst <= 1'b0;
        rd(PCIU_OFS_MASK0, 8'h00);
        rd(PCIU_OFS_MASK1, 8'h00);
        rd(PCIU_OFS_MASK2, 8'h00);
        wr(8'h00, 8'hFF);
        rd(8'h00, 8'h00);
        trial(8'hFE, 8'hFF, 8'hFF, 3'h7, 23'h000001, 1'b1);
        trial(8'hFF, 8'hFF, 8'hFF, 3'h6, 23'h000000, 1'b1);
        trial(8'hFF, 8'h80, 8'h01, 3'h7, 23'h7F7F00, 1'b0);
        repeat (14) trial(8'($urandom), 8'($urandom), 8'($urandom), 3'($urandom), 23'($urandom), 1'($urandom));
        trial(8'hFF, 8'hFF, 8'hFF, 3'h7, 23'h000000, 1'b1);
        core_en <= 1'b1;
        i_pins <= 23'h7FFFFF;
        for (n = 0; n < 30 && ack !== 3'h7; n++) tick(1);
        if (n == 30) begin
            failures++;
            test_done();
        end
        tick(4);
        rd(PCIU_OFS_FLAGS, 8'h00);
        test_done();
    end
endmodule // tb_pciu
